// ==== tb/dpram_checker_sva.sv ====
`include "dpram_map.vh"
module dpram_checker (
   input logic sys_clk,
   input logic rst_n,
   input logic out_reg_sel,
   input logic sr_mode,
   input logic en_a,
   input logic we_a,
   input logic [`ADDR_W-1:0] addr_a,
   input logic en_b,
   input logic we_b,
   input logic [`ADDR_W-1:0] addr_b,
   input logic rvalid_a_r,
   input logic rvalid_b_r,
   input logic collision_r,
   input logic [`WID_W-1:0] sr_width,
   input logic [`LEN_W-1:0] sr_tap_len,
   input logic [`WID_W-1:0] sr_taps,
   input logic cfg_ok_r,
   input logic sr_in_valid,
   input logic sr_in_ready,
   input logic tap_valid_r
);
   wire rd_a = en_a && !we_a;
   wire rd_b = en_b && !we_b;
   wire [31:0] vol = sr_width * sr_tap_len * sr_taps;
   wire geo_ok = sr_width != 0 && sr_tap_len != 0 && sr_taps != 0 && vol <= 9216 && sr_width * sr_taps <= 36;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence geom_held;
      (!sr_mode && $stable({sr_width, sr_tap_len, sr_taps}))[*3];
   endsequence
   sequence word_in;
      sr_in_valid && sr_in_ready && sr_mode && $past(sr_mode) && cfg_ok_r;
   endsequence
   chk_read_lat_a: assert property (rvalid_a_r |-> (out_reg_sel ? $past(rd_a, 2) : $past(rd_a)))
      else $error("port a data without request");
   chk_read_lat_b: assert property (rvalid_b_r |-> (out_reg_sel ? $past(rd_b, 2) : $past(rd_b)))
      else $error("port b data without request");
   chk_double_write: assert property (en_a && we_a && en_b && we_b && addr_a == addr_b
      && !sr_mode && !$past(sr_mode) |=> collision_r) else $error("double write not flagged");
   chk_geometry_limit: assert property (geom_held |-> cfg_ok_r == geo_ok)
      else $error("geometry verdict wrong");
   chk_tap_cause: assert property (tap_valid_r |-> $past(sr_mode, 2))
      else $error("shift outside shift mode");
   chk_tap_latency: assert property (word_in |-> ##[2:6] tap_valid_r)
      else $error("accepted word never shifted");
endmodule // dpram_checker
bind dpram_shifter dpram_checker chk_u (.*);

// ==== tb/dpram_shifter_tb.sv ====
`include "dpram_map.vh"
module dpram_shifter_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 0, rst_n = 0, out_reg_sel = 0, sr_mode = 0, en_a = 0, we_a = 0, en_b = 0, we_b = 0, go = 0;
   logic [`ADDR_W-1:0] addr_a = '0, addr_b = '0;
   logic [`WORD_W-1:0] wdata_a = '0, wdata_b = '0, rdata_a_r, rdata_b_r, sr_in_data, tap_out_r;
   logic [`WID_W-1:0] sr_width = '0, sr_taps = '0;
   logic [`LEN_W-1:0] sr_tap_len = '0;
   logic rvalid_a_r, rvalid_b_r, collision_r, cfg_ok_r, sr_in_valid, sr_in_ready, tap_valid_r;
   int mismatches = 0, checks = 0;
   dpram_shifter dut_u (.*);
   word_source src_u (.sys_clk, .rst_n, .go, .ready(sr_in_ready), .valid(sr_in_valid), .data(sr_in_data));
   initial forever #5 sys_clk = ~sys_clk;
   task automatic chk(input logic [35:0] got, exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic cyc(input logic [1:0] e, w, input logic [7:0] xa, xb, input logic [35:0] da, db);
      @(posedge sys_clk);
      {en_a, en_b} <= e;
      {we_a, we_b} <= w;
      addr_a <= xa;
      addr_b <= xb;
      wdata_a <= da;
      wdata_b <= db;
   endtask
   task automatic rd(input logic sel, input logic [7:0] xa, xb, input logic [35:0] ea, eb);
      @(posedge sys_clk);
      out_reg_sel <= sel;
      cyc(2'h3, 2'h0, xa, xb, '0, '0);
      cyc(2'h0, 2'h0, xa, xb, '0, '0);
      @(negedge sys_clk);
      chk(rvalid_a_r, !sel);
      if (sel) @(negedge sys_clk);
      chk({rvalid_a_r, rvalid_b_r}, 2'h3);
      chk(rdata_a_r, ea);
      chk(rdata_b_r, eb);
   endtask
   task automatic geo(input logic [5:0] w, n, input logic [13:0] m, input logic ok);
      @(posedge sys_clk);
      sr_width <= w;
      sr_taps <= n;
      sr_tap_len <= m;
      repeat (4) @(negedge sys_clk);
      chk(cfg_ok_r, ok);
   endtask
   task automatic t_ports();
      for (int s = 0; s < 2; s++) begin
         // Distinct addresses: the fabric side keeps writes apart
         cyc(2'h3, 2'h3, 8'h10 + s, 8'hff, 36'h900000001 + s, 36'h0a5a5a5a5);
         rd(s, 8'hff, 8'h10 + s, 36'h0a5a5a5a5, 36'h900000001 + s);
      end
   endtask
   task automatic t_collide();
      cyc(2'h3, 2'h3, 8'h20, 8'h20, 36'h1, 36'h2);
      cyc(2'h0, 2'h0, 8'h20, 8'h20, '0, '0);
      @(negedge sys_clk);
      chk(collision_r, 1);
      rd(0, 8'h20, 8'h20, 'x, 'x);
   endtask
   task automatic t_shift();
      int s = 0;
      @(posedge sys_clk);
      go <= 1;
      repeat (8) @(negedge sys_clk);
      chk(sr_in_ready, 0);
      @(posedge sys_clk);
      sr_mode <= 1;
      for (int i = 0; i < 200 && s < 12; i++) begin
         @(posedge sys_clk);
         go <= (i % 3 != 2);
         @(negedge sys_clk);
         if (tap_valid_r === 1'b1) begin
            for (int k = 1; k <= 3; k++)
               if (s >= 2 * k) chk(tap_out_r[(k-1)*4 +: 4], s - 2 * k);
            // Last tap is the word a cascaded block would take in
            if (s >= 6) chk(tap_out_r[11:8], s - 6);
            chk(tap_out_r[35:12], 0);
            s++;
         end
      end
      if (s < 12) begin
         mismatches++;
         wrap_up();
      end else begin
         @(posedge sys_clk);
         go <= 0;
         repeat (8) @(negedge sys_clk);
         chk(sr_in_ready, 1);
      end
   endtask
   initial begin
      repeat (5) @(posedge sys_clk);
      rst_n <= 1;
      t_ports();
      t_collide();
      geo(6'h04, 6'h09, 14'h100, 1);
      geo(6'h04, 6'h09, 14'h101, 0);
      geo(6'h07, 6'h05, 14'h001, 1);
      geo(6'h06, 6'h07, 14'h001, 0);
      geo(6'h00, 6'h01, 14'h001, 0);
      geo(6'h04, 6'h03, 14'h002, 1);
      t_shift();
      wrap_up();
   end
endmodule // dpram_shifter_tb

// ==== tb/word_source.sv ====
module word_source (
   input logic sys_clk,
   input logic rst_n,
   input logic go,
   input logic ready,
   output logic valid,
   output logic [35:0] data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [35:0] cnt_r;
   // Scrambled while idle so nothing leans on a stale word
   assign data = valid ? cnt_r : ~cnt_r;
   always @(posedge sys_clk) begin
      if (!rst_n) begin
         valid <= 1'b0;
         cnt_r <= 36'h0;
      end else if (valid && ready) begin
         cnt_r <= cnt_r + 36'h1;
         valid <= go;
      end else if (go) begin
         valid <= 1'b1;
      end
   end
endmodule // word_source

// ==== verilog/dpram_map.vh ====
`ifndef DPRAM_MAP_VH
`define DPRAM_MAP_VH

`define MEM_BITS 9216
`define WORD_W 36
`define ADDR_W 8
`define BASE_W 14
`define WID_W 6
`define LEN_W 14
`define PROD_W 32
`define MAX_TAP_BITS 36
`define FIFO_DEPTH 4
`define FIFO_AW 2
`define RST_WORD 36'h0

`endif

// ==== verilog/dpram_shifter.v ====
`include "dpram_map.vh"

module dpram_shifter (
   input wire sys_clk,
   input wire rst_n,
   input wire out_reg_sel,
   input wire sr_mode,
   input wire en_a,
   input wire we_a,
   input wire [`ADDR_W-1:0] addr_a,
   input wire [`WORD_W-1:0] wdata_a,
   output reg [`WORD_W-1:0] rdata_a_r,
   output reg rvalid_a_r,
   input wire en_b,
   input wire we_b,
   input wire [`ADDR_W-1:0] addr_b,
   input wire [`WORD_W-1:0] wdata_b,
   output reg [`WORD_W-1:0] rdata_b_r,
   output reg rvalid_b_r,
   output reg collision_r,
   input wire [`WID_W-1:0] sr_width,
   input wire [`LEN_W-1:0] sr_tap_len,
   input wire [`WID_W-1:0] sr_taps,
   output reg cfg_ok_r,
   input wire sr_in_valid,
   output wire sr_in_ready,
   input wire [`WORD_W-1:0] sr_in_data,
   output reg [`WORD_W-1:0] tap_out_r,
   output reg tap_valid_r
);
   reg [`MEM_BITS-1:0] mem_r;

   reg [`WORD_W-1:0] pipe_a_r;
   reg [`WORD_W-1:0] pipe_b_r;
   reg pipe_va_r;
   reg pipe_vb_r;
   reg sr_mode_r;
   reg [`WID_W-1:0] w_r;
   reg [`LEN_W-1:0] m_r;
   reg [`WID_W-1:0] n_r;
   reg [`LEN_W-1:0] ptr_r;
   reg [`LEN_W-1:0] ptr_nxt;
   reg [`WORD_W-1:0] row_new;
   reg [`WORD_W-1:0] wn_mask;
   reg [`WORD_W-1:0] w_mask;
   integer i;
   integer j;

   wire rd_a;
   wire rd_b;
   wire wr_a;
   wire wr_b;
   wire same_word;
   wire [`BASE_W-1:0] base_a;
   wire [`BASE_W-1:0] base_b;
   wire [`WORD_W-1:0] word_a;
   wire [`WORD_W-1:0] word_b;
   wire [`PROD_W-1:0] prod_wn;
   wire [`PROD_W-1:0] prod_wmn;
   wire cfg_ok;
   wire [`PROD_W-1:0] row_base_full;
   wire [`BASE_W-1:0] row_base;
   wire [`WORD_W-1:0] row_old;
   wire fifo_valid;
   wire fifo_ready;
   wire [`WORD_W-1:0] fifo_data;
   wire shift_go;

   // Memory ports only act outside shift mode
   assign rd_a = en_a & ~we_a & ~sr_mode_r;
   assign rd_b = en_b & ~we_b & ~sr_mode_r;
   assign wr_a = en_a & we_a & ~sr_mode_r;
   assign wr_b = en_b & we_b & ~sr_mode_r;
   assign same_word = (addr_a == addr_b);
   assign base_a = addr_a * 14'd36;
   assign base_b = addr_b * 14'd36;
   assign word_a = mem_r[base_a +: `WORD_W];
   assign word_b = mem_r[base_b +: `WORD_W];

   // Config check on live inputs, frozen copy used while shifting
   assign prod_wn = sr_width * sr_taps;
   assign prod_wmn = prod_wn * sr_tap_len;
   assign cfg_ok = (sr_width != {`WID_W{1'b0}}) && (sr_taps != {`WID_W{1'b0}}) &&
                   (sr_tap_len != {`LEN_W{1'b0}}) &&
                   (prod_wmn <= `MEM_BITS) &&
                   (prod_wn <= `MAX_TAP_BITS);

   assign row_base_full = ptr_r * (w_r * n_r);
   assign row_base = row_base_full[`BASE_W-1:0];
   // Bits past the top of the array read unknown but are masked off
   assign row_old = mem_r[row_base +: `WORD_W] & wn_mask;

   assign fifo_ready = sr_mode_r & cfg_ok_r;
   assign shift_go = fifo_valid & fifo_ready;

   word_fifo #(
      .WIDTH(`WORD_W),
      .DEPTH(`FIFO_DEPTH),
      .AW(`FIFO_AW)
   ) u_in_fifo (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .in_valid(sr_in_valid),
      .in_ready(sr_in_ready),
      .in_data(sr_in_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_ready),
      .out_data(fifo_data)
   );

   always @* begin
      wn_mask = {`WORD_W{1'b0}};
      w_mask = {`WORD_W{1'b0}};
      for (i = 0; i < `WORD_W; i = i + 1) begin
         if (i < w_r * n_r) begin
            wn_mask[i] = 1'b1;
         end
         if (i < w_r) begin
            w_mask[i] = 1'b1;
         end
      end
   end

   // Each stage slides up one word; oldest stage falls off the top
   always @* begin
      row_new = ((row_old << w_r) | (fifo_data & w_mask)) & wn_mask;
      if (ptr_r >= m_r - 1'b1) begin
         ptr_nxt = {`LEN_W{1'b0}};
      end else begin
         ptr_nxt = ptr_r + 1'b1;
      end
   end

   // Array itself is not reset; contents are undefined until written
   always @(posedge sys_clk) begin
      if (!sr_mode_r) begin
         if (wr_a && wr_b && same_word) begin
            mem_r[base_a +: `WORD_W] <= {`WORD_W{1'bx}};
         end else begin
            if (wr_a) begin
               mem_r[base_a +: `WORD_W] <= wdata_a;
            end
            if (wr_b) begin
               mem_r[base_b +: `WORD_W] <= wdata_b;
            end
         end
      end else if (shift_go) begin
         for (j = 0; j < `WORD_W; j = j + 1) begin
            if (j < w_r * n_r) begin
               mem_r[row_base + j] <= row_new[j];
            end
         end
      end
   end

   always @(posedge sys_clk) begin
      if (!rst_n) begin
         pipe_a_r <= `RST_WORD;
         pipe_b_r <= `RST_WORD;
         pipe_va_r <= 1'b0;
         pipe_vb_r <= 1'b0;
         rdata_a_r <= `RST_WORD;
         rdata_b_r <= `RST_WORD;
         rvalid_a_r <= 1'b0;
         rvalid_b_r <= 1'b0;
         collision_r <= 1'b0;
      end else begin
         // Read returns the old word when a write hits the same address
         pipe_a_r <= word_a;
         pipe_b_r <= word_b;
         pipe_va_r <= rd_a;
         pipe_vb_r <= rd_b;
         if (out_reg_sel) begin
            rdata_a_r <= pipe_va_r ? pipe_a_r : rdata_a_r;
            rdata_b_r <= pipe_vb_r ? pipe_b_r : rdata_b_r;
            rvalid_a_r <= pipe_va_r;
            rvalid_b_r <= pipe_vb_r;
         end else begin
            rdata_a_r <= rd_a ? word_a : rdata_a_r;
            rdata_b_r <= rd_b ? word_b : rdata_b_r;
            rvalid_a_r <= rd_a;
            rvalid_b_r <= rd_b;
         end
         // Flag only; no arbitration, the user must avoid this
         collision_r <= wr_a & wr_b & same_word;
      end
   end

   always @(posedge sys_clk) begin
      if (!rst_n) begin
         sr_mode_r <= 1'b0;
         w_r <= {`WID_W{1'b0}};
         m_r <= {`LEN_W{1'b0}};
         n_r <= {`WID_W{1'b0}};
         cfg_ok_r <= 1'b0;
         ptr_r <= {`LEN_W{1'b0}};
         tap_out_r <= `RST_WORD;
         tap_valid_r <= 1'b0;
      end else begin
         sr_mode_r <= sr_mode;
         tap_valid_r <= 1'b0;
         if (!sr_mode_r) begin
            // Geometry only changes outside shift mode
            w_r <= sr_width;
            m_r <= sr_tap_len;
            n_r <= sr_taps;
            cfg_ok_r <= cfg_ok;
            ptr_r <= {`LEN_W{1'b0}};
         end else if (shift_go) begin
            ptr_r <= ptr_nxt;
            tap_out_r <= row_old;
            tap_valid_r <= 1'b1;
         end
      end
   end
endmodule // dpram_shifter

// ==== verilog/word_fifo.v ====
module word_fifo #(
   parameter WIDTH = 36,
   parameter DEPTH = 4,
   parameter AW = 2
) (
   input wire sys_clk,
   input wire rst_n,
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] slot_r [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_r;
   reg [AW-1:0] rd_ptr_r;
   reg [AW:0] count_r;
   reg in_ready_r;
   reg empty_r;
   wire push;
   wire pop;
   reg [AW:0] count_nxt;

   // Kept as its own flop so ready leaves with no gate behind it
   assign in_ready = in_ready_r;
   assign out_valid = ~empty_r;
   assign out_data = slot_r[rd_ptr_r];
   assign push = in_valid & in_ready_r;
   assign pop = out_ready & ~empty_r;

   always @* begin
      count_nxt = count_r;
      if (push && !pop) begin
         count_nxt = count_r + 1'b1;
      end else if (pop && !push) begin
         count_nxt = count_r - 1'b1;
      end
   end

   always @(posedge sys_clk) begin
      if (push) begin
         slot_r[wr_ptr_r] <= in_data;
      end
   end

   always @(posedge sys_clk) begin
      if (!rst_n) begin
         wr_ptr_r <= {AW{1'b0}};
         rd_ptr_r <= {AW{1'b0}};
         count_r <= {(AW+1){1'b0}};
         in_ready_r <= 1'b1;
         empty_r <= 1'b1;
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == DEPTH - 1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == DEPTH - 1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
         end
         count_r <= count_nxt;
         in_ready_r <= (count_nxt != DEPTH);
         empty_r <= (count_nxt == {(AW+1){1'b0}});
      end
   end
endmodule // word_fifo
